//--- design/spr_seq_pkg.sv
// Purpose: Constants and types for the sensor power and reset sequencer host.
// Assumes: Core clock at 25 MHz, 40 ns period.
// Notes: The off-hold and init counts are also top-level parameters so simulation can shorten them.
package spr_seq_pkg;
    // ==========================================================
    // Clock rate
    localparam int CORE_CLK_HZ = 25_000_000;
    localparam int CORE_CLK_NS = 40;

    // ==========================================================
    // Required times, in their own units
    localparam int RAIL_STEP_US = 10;
    localparam int HARD_RESET_MS = 1;
    localparam int INIT_INPUT_CLKS = 160000;
    localparam int PLL_LOCK_MS = 1;
    localparam int OFF_HOLD_MS = 100;

    // ==========================================================
    // Cycle counts derived from the clock rate
    // Rail step is a longest time, so it rounds down; the rest are least times and round up.
    localparam int RAIL_STEP_CYC = (RAIL_STEP_US * 1000) / CORE_CLK_NS;
    localparam int HARD_RESET_CYC = (HARD_RESET_MS * 1000000 + CORE_CLK_NS - 1) / CORE_CLK_NS;
    localparam int PLL_LOCK_CYC = (PLL_LOCK_MS * 1000000 + CORE_CLK_NS - 1) / CORE_CLK_NS;
    localparam longint OFF_HOLD_CYC = (64'(OFF_HOLD_MS) * 1000000 + CORE_CLK_NS - 1) / CORE_CLK_NS;

    // ==========================================================
    // Sensor register layout
    localparam logic [15:0] SENSOR_CONTROL_REGISTER_ADDR = 16'h301A;
    localparam int STREAM_BIT_POS = 2;

    // ==========================================================
    // Rail vector bit positions
    localparam int RAIL_PLL = 0;
    localparam int RAIL_ANALOG = 1;
    localparam int RAIL_IO = 2;
    localparam int RAIL_CORE = 3;
    localparam int RAIL_SERIAL = 4;
    localparam int RAIL_CNT = 5;
    localparam int CNT_W = 32;
    localparam logic [RAIL_CNT-1:0] RAILS_OFF = 5'h00;

    typedef enum logic [3:0] {
        SPR_OFF_HOLD, SPR_OFF, SPR_RAIL_UP, SPR_CLK_ON, SPR_RESET, SPR_INIT,
        SPR_CONFIG, SPR_PLL_WAIT, SPR_START, SPR_STREAM, SPR_STOP,
        SPR_STOP_WAIT, SPR_CLK_OFF, SPR_RAIL_DOWN
    } spr_state_t;

    typedef struct packed {
        spr_state_t state;
        logic [CNT_W-1:0] cnt;
        logic [2:0] railIdx;
        logic [RAIL_CNT-1:0] rails;
        logic clkEn;
        logic resetN;
        logic wrReq;
        logic [15:0] wrAddr;
        logic [15:0] wrData;
        logic cfgEn;
        logic ready;
        logic streaming;
    } spr_seq_t;
endpackage

//--- design/spr_seq_host.sv
// Purpose: Host-side controller that powers, resets, starts and stops an image sensor.
// Assumes: Rail-good and standby flags and write acknowledge are synchronous to core_clk.
// Notes: The serial control port itself lives outside; this block issues write requests.
//
// Contract
// - PLL rail first, never after others
// - Start input clock after rails stable
// - Hold hard reset low at least 1 ms
// - Count reset time from rails settled
// - Wait 160000 input clocks after reset release
// - Configure sensor during software standby
// - Wait 1 ms PLL lock before streaming
// - Streaming bit 2 at 0x301a starts output
// - Clear streaming bit before power-down
// - Rails down serial, core, IO, analog, PLL
// - Keep rails off at least 100 ms
`timescale 1ns/1ns
module spr_seq_host #(
    parameter int OFF_HOLD_CYCLES = int'(spr_seq_pkg::OFF_HOLD_CYC),
    parameter int INIT_CYCLES = spr_seq_pkg::INIT_INPUT_CLKS
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clkEnable,
    input wire logic powerUpReq,
    input wire logic powerDownReq,
    input wire logic cfgDone,
    input wire logic [spr_seq_pkg::RAIL_CNT-1:0] railGood,
    input wire logic extClkTick,
    input wire logic sensorStandby,
    input wire logic wrAck,
    output logic [spr_seq_pkg::RAIL_CNT-1:0] railEnable,
    output logic externalInputClockEn,
    output logic sensorResetN,
    output logic wrReq,
    output logic [15:0] wrAddr,
    output logic [15:0] wrData,
    output logic cfgEnable,
    output logic seqReady,
    output logic seqStreaming
);
    import spr_seq_pkg::*;

    // ==========================================================
    // State
    spr_seq_t cur_ff;
    spr_seq_t nxt_cur;

    // Power-up order: PLL first, core and serial last
    function automatic logic [RAIL_CNT-1:0] railsUpTo(input logic [2:0] idx);
        logic [RAIL_CNT-1:0] m;
        m = RAILS_OFF;
        for (int i = 0; i < RAIL_CNT; i++) begin
            if (i <= int'(idx)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Terminal count test shared by every counted wait state
    function automatic logic reached(input logic [CNT_W-1:0] c, input int lim);
        return c >= CNT_W'(lim - 1);
    endfunction

    // ==========================================================
    // Sequencer
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.cnt = cur_ff.cnt + CNT_W'(1);
        nxt_cur.wrReq = 1'b0;
        unique case (cur_ff.state)
            SPR_OFF_HOLD: begin
                // Decoupling must discharge before another power-up
                if (reached(cur_ff.cnt, OFF_HOLD_CYCLES)) begin
                    nxt_cur.state = SPR_OFF;
                end
            end
            SPR_OFF: begin
                // Request is a level; it is only looked at here
                nxt_cur.cnt = '0;
                if (powerUpReq) begin
                    nxt_cur.rails = railsUpTo(3'h0);
                    nxt_cur.railIdx = 3'h0;
                    nxt_cur.resetN = 1'b0;
                    nxt_cur.state = SPR_RAIL_UP;
                end
            end
            SPR_RAIL_UP: begin
                // Step at the 10 us limit even if the rail is slow, never later
                if (railGood[cur_ff.railIdx] || reached(cur_ff.cnt, RAIL_STEP_CYC)) begin
                    nxt_cur.cnt = '0;
                    if (cur_ff.railIdx == 3'(RAIL_CNT - 1)) begin
                        nxt_cur.state = SPR_CLK_ON;
                    end else begin
                        nxt_cur.railIdx = cur_ff.railIdx + 3'h1;
                        nxt_cur.rails = railsUpTo(cur_ff.railIdx + 3'h1);
                    end
                end
            end
            SPR_CLK_ON: begin
                // Reset time starts once every rail reports stable
                nxt_cur.cnt = '0;
                if (&railGood) begin
                    nxt_cur.clkEn = 1'b1;
                    nxt_cur.state = SPR_RESET;
                end
            end
            SPR_RESET: begin
                // Sensor reset has been low since power-up; count the hold here
                if (reached(cur_ff.cnt, HARD_RESET_CYC)) begin
                    nxt_cur.resetN = 1'b1;
                    nxt_cur.cnt = '0;
                    nxt_cur.state = SPR_INIT;
                end
            end
            SPR_INIT: begin
                // Counts sensor input clocks, not core clocks
                nxt_cur.cnt = extClkTick ? cur_ff.cnt + CNT_W'(1) : cur_ff.cnt;
                if (extClkTick && reached(cur_ff.cnt, INIT_CYCLES)) begin
                    nxt_cur.cfgEn = 1'b1;
                    nxt_cur.state = SPR_CONFIG;
                end
            end
            SPR_CONFIG: begin
                // Sensor sits in software standby while the user configures it
                nxt_cur.cnt = '0;
                if (cfgDone) begin
                    nxt_cur.cfgEn = 1'b0;
                    nxt_cur.state = SPR_PLL_WAIT;
                end
            end
            SPR_PLL_WAIT: begin
                // Lock wait starts only once configuration is finished
                if (reached(cur_ff.cnt, PLL_LOCK_CYC)) begin
                    nxt_cur.wrReq = 1'b1;
                    nxt_cur.wrAddr = SENSOR_CONTROL_REGISTER_ADDR;
                    nxt_cur.wrData = 16'h0000;
                    nxt_cur.wrData[STREAM_BIT_POS] = 1'b1;
                    nxt_cur.state = SPR_START;
                end
            end
            SPR_START: begin
                // Hold the write up until the port acknowledges it
                nxt_cur.wrReq = ~wrAck;
                if (wrAck) begin
                    nxt_cur.streaming = 1'b1;
                    nxt_cur.ready = 1'b1;
                    nxt_cur.state = SPR_STREAM;
                end
            end
            SPR_STREAM: begin
                // Stop is only honoured once streaming is established
                if (powerDownReq) begin
                    nxt_cur.wrReq = 1'b1;
                    nxt_cur.wrData = 16'h0000;
                    nxt_cur.ready = 1'b0;
                    nxt_cur.state = SPR_STOP;
                end
            end
            SPR_STOP: begin
                // Same handshake as the start write; address is unchanged
                nxt_cur.wrReq = ~wrAck;
                if (wrAck) begin
                    nxt_cur.streaming = 1'b0;
                    nxt_cur.state = SPR_STOP_WAIT;
                end
            end
            SPR_STOP_WAIT: begin
                // Sensor drains its row or frame first
                if (sensorStandby) begin
                    nxt_cur.state = SPR_CLK_OFF;
                end
            end
            SPR_CLK_OFF: begin
                // Clock and reset go first so no rail drops under a running sensor
                nxt_cur.clkEn = 1'b0;
                nxt_cur.resetN = 1'b0;
                nxt_cur.railIdx = 3'(RAIL_CNT - 1);
                nxt_cur.state = SPR_RAIL_DOWN;
            end
            SPR_RAIL_DOWN: begin
                // Zero gap allowed; one rail per cycle keeps the order visible
                nxt_cur.rails[cur_ff.railIdx] = 1'b0;
                nxt_cur.railIdx = cur_ff.railIdx - 3'h1;
                nxt_cur.cnt = '0;
                if (cur_ff.railIdx == 3'(RAIL_PLL)) begin
                    nxt_cur.state = SPR_OFF_HOLD;
                end
            end
            default: begin
                nxt_cur.state = SPR_OFF_HOLD;
            end
        endcase
    end

    // ==========================================================
    // Register; off-hold at reset since rails may have just dropped
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cur_ff <= '{state: SPR_OFF_HOLD, cnt: '0, railIdx: 3'h0, rails: RAILS_OFF,
                        clkEn: 1'b0, resetN: 1'b0, wrReq: 1'b0, wrAddr: 16'h0000,
                        wrData: 16'h0000, cfgEn: 1'b0, ready: 1'b0, streaming: 1'b0};
        end else if (clkEnable) begin
            cur_ff <= nxt_cur;
        end
    end

    // Outputs straight from flip-flops
    assign railEnable = cur_ff.rails;
    assign externalInputClockEn = cur_ff.clkEn;
    assign sensorResetN = cur_ff.resetN;
    assign wrReq = cur_ff.wrReq;
    assign wrAddr = cur_ff.wrAddr;
    assign wrData = cur_ff.wrData;
    assign cfgEnable = cur_ff.cfgEn;
    assign seqReady = cur_ff.ready;
    assign seqStreaming = cur_ff.streaming;
endmodule

//--- tb/spr_seq_host_chk.sv
// Purpose: Port assertions for the sequencer host
// Assumes: One clock domain
// Notes: Counters stand in for the long waits
`timescale 1ns/1ns
module spr_seq_host_chk #(
    parameter int OFF_HOLD_CYCLES = 20,
    parameter int INIT_CYCLES = 8
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [spr_seq_pkg::RAIL_CNT-1:0] railGood,
    input wire logic extClkTick,
    input wire logic sensorStandby,
    input wire logic wrAck,
    input wire logic [spr_seq_pkg::RAIL_CNT-1:0] railEnable,
    input wire logic externalInputClockEn,
    input wire logic sensorResetN,
    input wire logic wrReq,
    input wire logic [15:0] wrData,
    input wire logic cfgEnable
);
    import spr_seq_pkg::*;
    int lowCnt, idleCnt, offCnt, tickCnt;
    // ==========
    // Elapsed cycles, input clock ticks for tickCnt; each clears when its condition ends
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lowCnt <= 0;
            idleCnt <= 0;
            offCnt <= 0;
            tickCnt <= 0;
        end else begin
            lowCnt <= (sensorResetN || !externalInputClockEn) ? 0 : lowCnt + 1;
            idleCnt <= cfgEnable ? 0 : idleCnt + 1;
            offCnt <= (railEnable != RAILS_OFF) ? 0 : offCnt + 1;
            tickCnt <= !sensorResetN ? 0 : tickCnt + int'(extClkTick);
        end
    end
    // ==========
    // Properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_wrPending;
        wrReq && !wrAck;
    endsequence
    property p_pllFirst; railEnable != RAILS_OFF |-> railEnable[RAIL_PLL]; endproperty
    property p_railShape; 1'b1 |-> (railEnable & (railEnable + 5'h01)) == 5'h00; endproperty
    property p_railStep; $changed(railEnable) |-> $onehot(railEnable ^ $past(railEnable)); endproperty
    property p_clkAfterRails; $rose(externalInputClockEn) |-> &$past(railGood); endproperty
    property p_resetHold; $rose(sensorResetN) |-> lowCnt >= HARD_RESET_CYC - 1; endproperty
    property p_initWait; $rose(cfgEnable) |-> tickCnt >= INIT_CYCLES; endproperty
    property p_pllLock; $rose(wrReq) && wrData[STREAM_BIT_POS] |-> idleCnt >= PLL_LOCK_CYC - 1; endproperty
    property p_writeHold; s_wrPending |=> wrReq && $stable(wrData); endproperty
    property p_standbyFirst; $fell(externalInputClockEn) |-> $past(sensorStandby); endproperty
    property p_offHold; $rose(railEnable[RAIL_PLL]) |-> offCnt >= OFF_HOLD_CYCLES - 1; endproperty
    a_pllFirst: assert property (p_pllFirst) else $error("PLL rail not first");
    a_railShape: assert property (p_railShape) else $error("rail order broken");
    a_railStep: assert property (p_railStep) else $error("two rails in one step");
    a_clkAfterRails: assert property (p_clkAfterRails) else $error("clock before rails good");
    a_resetHold: assert property (p_resetHold) else $error("hard reset too short");
    a_initWait: assert property (p_initWait) else $error("config before init");
    a_pllLock: assert property (p_pllLock) else $error("stream before lock");
    a_writeHold: assert property (p_writeHold) else $error("write dropped early");
    a_standbyFirst: assert property (p_standbyFirst) else $error("clock off in stream");
    a_offHold: assert property (p_offHold) else $error("off time too short");
endmodule
bind spr_seq_host spr_seq_host_chk #(.OFF_HOLD_CYCLES(OFF_HOLD_CYCLES), .INIT_CYCLES(INIT_CYCLES)) chk (
    .core_clk(core_clk), .rstn(rstn), .railGood(railGood), .extClkTick(extClkTick),
    .sensorStandby(sensorStandby), .wrAck(wrAck), .railEnable(railEnable), .externalInputClockEn(externalInputClockEn),
    .sensorResetN(sensorResetN), .wrReq(wrReq), .wrData(wrData), .cfgEnable(cfgEnable));

//--- tb/spr_sensor_model.sv
// Purpose: Behavioural image sensor at the far side
// Assumes: Input clock ticks every other core cycle
// Notes: ROW_CYCLES makes standby entry slow
`timescale 1ns/1ns
module spr_sensor_model #(
    parameter int INIT_CYCLES = 8,
    parameter int ROW_CYCLES = 12
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [spr_seq_pkg::RAIL_CNT-1:0] railEnable,
    input wire logic externalInputClockEn,
    input wire logic sensorResetN,
    input wire logic wrReq,
    input wire logic [15:0] wrAddr,
    input wire logic [15:0] wrData,
    output logic [spr_seq_pkg::RAIL_CNT-1:0] railGood,
    output logic extClkTick,
    output logic sensorStandby,
    output logic wrAck
);
    import spr_seq_pkg::*;
    int initCnt, rowCnt;
    logic streamOn;
    logic hit;
    // Standby only once init is done and the last row has drained
    assign sensorStandby = initCnt == INIT_CYCLES && !streamOn && rowCnt == 0;
    assign hit = wrReq && wrAck && wrAddr == SENSOR_CONTROL_REGISTER_ADDR;
    // Rails settle in one cycle; writes are acked only after init
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            railGood <= '0;
            extClkTick <= 1'b0;
            wrAck <= 1'b0;
            initCnt <= 0;
            rowCnt <= 0;
            streamOn <= 1'b0;
        end else begin
            railGood <= railEnable;
            extClkTick <= externalInputClockEn && !extClkTick;
            wrAck <= wrReq && !wrAck && initCnt == INIT_CYCLES;
            if (!sensorResetN) begin
                initCnt <= 0;
                streamOn <= 1'b0;
            end else if (initCnt < INIT_CYCLES) begin
                initCnt <= initCnt + int'(extClkTick);
            end else if (hit) begin
                streamOn <= wrData[STREAM_BIT_POS];
            end
            if (hit && streamOn && !wrData[STREAM_BIT_POS]) begin
                rowCnt <= ROW_CYCLES;
            end else if (rowCnt != 0) begin
                rowCnt <= rowCnt - 1;
            end
        end
    end
endmodule

//--- tb/test_spr_seq_host.sv
// Purpose: Self-checking bench for the sequencer host
// Assumes: Short off-hold and init counts
// Notes: One power-up and one power-down fit the run
`timescale 1ns/1ns
module test_spr_seq_host;
    import spr_seq_pkg::*;
    logic core_clk = 1'b0, rstn = 1'b0, clkEnable = 1'b1;
    logic powerUpReq = 1'b0, powerDownReq = 1'b0, cfgDone = 1'b0;
    logic [RAIL_CNT-1:0] railGood, railEnable, prevRails;
    logic extClkTick, sensorStandby, wrAck, externalInputClockEn, sensorResetN, wrReq, cfgEnable, seqReady, seqStreaming;
    logic [15:0] wrAddr, wrData;
    int nErrors = 0, checkCount = 0, cyc = 0, i;
    localparam logic [4:0] RAIL_SEQ [5] = '{5'h0F, 5'h07, 5'h03, 5'h01, 5'h00};
    always #20 core_clk = ~core_clk;
    spr_seq_host #(.OFF_HOLD_CYCLES(20), .INIT_CYCLES(8)) uut (.core_clk(core_clk), .rstn(rstn),
        .clkEnable(clkEnable), .powerUpReq(powerUpReq), .powerDownReq(powerDownReq), .cfgDone(cfgDone),
        .railGood(railGood), .extClkTick(extClkTick), .sensorStandby(sensorStandby), .wrAck(wrAck),
        .railEnable(railEnable), .externalInputClockEn(externalInputClockEn), .sensorResetN(sensorResetN),
        .wrReq(wrReq), .wrAddr(wrAddr), .wrData(wrData), .cfgEnable(cfgEnable), .seqReady(seqReady),
        .seqStreaming(seqStreaming));
    spr_sensor_model #(.INIT_CYCLES(8)) partner (.core_clk(core_clk), .rstn(rstn), .railEnable(railEnable),
        .externalInputClockEn(externalInputClockEn), .sensorResetN(sensorResetN), .wrReq(wrReq), .wrAddr(wrAddr),
        .wrData(wrData), .railGood(railGood), .extClkTick(extClkTick), .sensorStandby(sensorStandby), .wrAck(wrAck));
    // Compare and count; prints at once on a miss
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checkCount++;
        if (got !== exp) begin
            nErrors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic t_reset_and_hold;
        repeat (4) @(posedge core_clk);
        chk("reset low", 16'h0000, {15'h0000, sensorResetN});
        rstn <= 1'b1;
        powerUpReq <= 1'b1;
        powerDownReq <= 1'b1;
        repeat (16) @(posedge core_clk);
        chk("rails in hold", 16'h0000, {11'h000, railEnable});
        powerDownReq <= 1'b0;
        for (i = 0; i < 20 && railEnable === 5'h00; i++) @(posedge core_clk);
        chk("first rail", 16'h0001, {11'h000, railEnable});
        powerUpReq <= 1'b0;
        $display("done reset and hold");
    endtask
    task automatic t_power_up;
        for (i = 0; i < 2000 && externalInputClockEn !== 1'b1; i++) @(posedge core_clk);
        chk("rails before clock", 16'h001F, {11'h000, railEnable});
        for (i = 0; i < 30000 && sensorResetN !== 1'b1; i++) @(posedge core_clk);
        chk("reset length", 16'h0001, {15'h0000, sensorResetN === 1'b1 && i >= HARD_RESET_CYC - 1});
        for (i = 0; i < 100 && cfgEnable !== 1'b1; i++) @(posedge core_clk);
        chk("standby at config", 16'h0001, {15'h0000, sensorStandby});
        cfgDone <= 1'b1;
        for (i = 0; i < 30000 && wrReq !== 1'b1; i++) @(posedge core_clk);
        cfgDone <= 1'b0;
        chk("lock wait", 16'h0001, {15'h0000, wrReq === 1'b1 && i >= PLL_LOCK_CYC});
        chk("start addr", SENSOR_CONTROL_REGISTER_ADDR, wrAddr);
        chk("start data", 16'h0004, wrData);
        for (i = 0; i < 20 && seqStreaming !== 1'b1; i++) @(posedge core_clk);
        chk("streaming", 16'h0003, {14'h0000, seqReady, ~sensorStandby});
        $display("done power up");
    endtask
    task automatic t_power_down;
        clkEnable <= 1'b0;
        powerDownReq <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk("frozen", 16'h0000, {14'h0000, wrReq, ~seqStreaming});
        clkEnable <= 1'b1;
        for (i = 0; i < 100 && wrReq !== 1'b1; i++) @(posedge core_clk);
        powerDownReq <= 1'b0;
        chk("stop data", 16'h0000, wrData);
        for (i = 0; i < 100 && externalInputClockEn !== 1'b0; i++) @(posedge core_clk);
        chk("standby at clock off", 16'h0001, {15'h0000, sensorStandby});
        chk("stopped", 16'h0000, {13'h0000, seqReady, seqStreaming, sensorResetN});
        for (int k = 0; k < 5; k++) begin
            prevRails = railEnable;
            for (i = 0; i < 20 && railEnable === prevRails; i++) @(posedge core_clk);
            chk("rail off step", {11'h000, RAIL_SEQ[k]}, {11'h000, railEnable});
        end
        $display("done power down");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Cut a hang short well past the expected run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 80000) begin
            nErrors++;
            end_of_test();
        end
    end
    initial begin
        t_reset_and_hold();
        t_power_up();
        t_power_down();
        end_of_test();
    end
endmodule
